//--- verilog/fmlr_pkg.sv
/*
  constants, state codes and the lock-bit index map shared by the flash
  mode, lock and reset command logic. assumes a 125 MHz core clock and
  a 24-bit (16 MB) array split into 64 KB blocks.
*/
`default_nettype none
package fmlr_pkg;

  // instruction codes
  localparam logic [7:0] OPC_WRAP_READ     = 8'h0C;
  localparam logic [7:0] OPC_ENTER_QUAD    = 8'h38;
  localparam logic [7:0] OPC_EXIT_QUAD     = 8'hFF;
  localparam logic [7:0] OPC_LOCK          = 8'h36;
  localparam logic [7:0] OPC_UNLOCK        = 8'h39;
  localparam logic [7:0] OPC_READ_LOCK     = 8'h3D;
  localparam logic [7:0] OPC_GLOBAL_LOCK   = 8'h7E;
  localparam logic [7:0] OPC_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OPC_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] OPC_RESET         = 8'h99;

  // field sizes in bits
  localparam logic [4:0] OPC_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;

  // read parameters after reset: 2 dummy clocks, 8-byte wrap
  localparam logic [7:0] RD_PARAM_RST = 8'h00;
  localparam int         DUMMY_POS    = 4;
  localparam int         WRAP_POS     = 0;

  // software reset recovery time
  localparam int          RESET_TIME_US = 30;
  localparam int          CORE_CLK_MHZ  = 125;
  localparam logic [11:0] RESET_CYCLES  = 12'(RESET_TIME_US * CORE_CLK_MHZ);

  // pin sync reset value {cs_n, sclk, io[3:0]}
  localparam logic [5:0] PIN_RST = 6'h20;

  // lock bits: 16 sectors at each end block, one bit per middle block
  localparam int         LOCK_BITS = 286;
  localparam int         LOCK_IW   = 9;
  localparam logic [8:0] TOP_SECT0 = 9'h010;
  localparam logic [8:0] MID_BASE  = 9'h01F;

  // range protection spans
  localparam logic [24:0] SECTOR_SPAN = 25'h000_1000;
  localparam logic [24:0] BLOCK_SPAN  = 25'h001_0000;
  localparam logic [24:0] ARRAY_END   = 25'h100_0000;

  typedef enum logic [4:0] {
    ST_OPC   = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_DUMMY = 5'b00100,
    ST_DATA  = 5'b01000,
    ST_SKIP  = 5'b10000
  } fmlr_state_t;

  // end blocks lock per 4 KB sector, the others per 64 KB block
  function automatic logic [8:0] fmlr_lock_index(input logic [23:0] a);
    logic [8:0] idx;
    if (a[23:16] == 8'h00) begin
      idx = {5'h00, a[15:12]};
    end else if (a[23:16] == 8'hFF) begin
      idx = TOP_SECT0 + {5'h00, a[15:12]};
    end else begin
      idx = MID_BASE + {1'b0, a[23:16]};
    end
    return idx;
  endfunction

endpackage
`default_nettype wire

//--- verilog/fmlr_sync.sv
/*
  two-flop synchroniser for a group of pins.
  assumes each bit is a slow level; no bit alignment between bits.
*/
`timescale 1ns/1ps
`default_nettype none
module fmlr_sync #(
  parameter int           W       = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= RST_VAL;
      q_o     <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule
`default_nettype wire

//--- verilog/fmlr_lockmem.sv
/*
  volatile block/sector lock bits with single and global set/clear and
  two combinational read ports. assumes one-cycle command pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module fmlr_lockmem #(
  parameter int N  = 286,
  parameter int IW = 9
) (
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          set_i,
  input  wire logic          clr_i,
  input  wire logic [IW-1:0] idx_i,
  input  wire logic          all_set_i,
  input  wire logic          all_clr_i,
  input  wire logic [IW-1:0] rd_a_idx_i,
  output var  logic          rd_a_o,
  input  wire logic [IW-1:0] rd_b_idx_i,
  output var  logic          rd_b_o
);

  logic [N-1:0] lock_ff;

  // everything locked out of reset so the array starts protected
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_ff <= '1;
    end else if (all_set_i) begin
      lock_ff <= '1;
    end else if (all_clr_i) begin
      lock_ff <= '0;
    end else if (set_i && (int'(idx_i) < N)) begin
      lock_ff[idx_i] <= 1'b1;
    end else if (clr_i && (int'(idx_i) < N)) begin
      lock_ff[idx_i] <= 1'b0;
    end
  end

  // out-of-range index reads as locked
  always_comb begin
    rd_a_o = (int'(rd_a_idx_i) < N) ? lock_ff[rd_a_idx_i] : 1'b1;
    rd_b_o = (int'(rd_b_idx_i) < N) ? lock_ff[rd_b_idx_i] : 1'b1;
  end

endmodule
`default_nettype wire

//--- verilog/fmlr_core.sv
/*
  serial flash command logic: quad-wide command mode entry and exit,
  wrapped burst read, block/sector locks and the two-step software
  reset. assumes the serial clock half period spans at least three
  core clocks, and that array data on rd_data_i follows rd_addr_o
  within one core clock. status bits arrive on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fmlr_core
  import fmlr_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  io_i,
  output var  logic [3:0]  io_o,
  output var  logic [3:0]  io_oe_n_o,
  input  wire logic        quad_enable_i,
  input  wire logic        write_enable_latch_i,
  input  wire logic        per_region_protect_select_i,
  input  wire logic        protect_complement_i,
  input  wire logic        small_region_select_i,
  input  wire logic        top_bottom_select_i,
  input  wire logic [2:0]  protect_range_bits_i,
  input  wire logic [23:0] prot_addr_i,
  input  wire logic        param_load_i,
  input  wire logic [7:0]  read_parameter_bits_i,
  input  wire logic [7:0]  rd_data_i,
  output var  logic [23:0] rd_addr_o,
  output var  logic        quad_wide_command_mode_o,
  output var  logic [7:0]  read_parameter_bits_o,
  output var  logic        reset_busy_o,
  output var  logic        sw_reset_o,
  output var  logic        array_protect_o
);

  logic [5:0]  pins_s;
  logic        cs_n_s;
  logic        sclk_s;
  logic [3:0]  io_s;
  logic        sclk_d_ff;
  logic        cs_d_ff;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  fmlr_state_t state_ff;
  fmlr_state_t nxt_state_opc;
  logic [7:0]  opc_ff;
  logic [7:0]  nxt_opc;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic [4:0]  cnt_ff;
  logic [4:0]  cnt_sum;
  logic [4:0]  step;
  logic [3:0]  dcnt_ff;
  logic [3:0]  dummy_clks;
  logic        overrun_ff;
  logic        arm_ok_ff;
  logic        opc_done;
  logic        addr_done;
  logic        armed_ff;
  logic [11:0] busy_cnt_ff;
  logic        frame_ok;
  logic        ex_enter;
  logic        ex_exit;
  logic        ex_lock;
  logic        ex_unlock;
  logic        ex_glock;
  logic        ex_gunlock;
  logic        ex_arm;
  logic        ex_reset;
  logic [7:0]  tx_ff;
  logic [7:0]  tx_byte;
  logic [2:0]  ocnt_ff;
  logic [23:0] wrap_mask;
  logic [23:0] wrap_next;
  logic        lock_rd;
  logic        lock_prot;
  logic [24:0] span;
  logic        in_range;
  // pins are asynchronous to the core clock
  fmlr_sync #(
    .W       (6),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .d_i        ({cs_n_i, sclk_i, io_i}),
    .q_o        (pins_s)
  );

  assign cs_n_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s   = pins_s[3:0];

  // edge history of the synchronised pins
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_n_s;
    end
  end

  assign rise    = sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign fall    = ~sclk_s & sclk_d_ff & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_d_ff;

  // field shifting: one bit on io0 in spi mode, a nibble in quad mode
  always_comb begin
    step = quad_wide_command_mode_o ? 5'h04 : 5'h01;
    cnt_sum = cnt_ff + step;
    if (quad_wide_command_mode_o) begin
      nxt_opc  = {opc_ff[3:0], io_s};
      nxt_addr = {addr_ff[19:0], io_s};
    end else begin
      nxt_opc  = {opc_ff[6:0], io_s[0]};
      nxt_addr = {addr_ff[22:0], io_s[0]};
    end
    dummy_clks = {1'b0, read_parameter_bits_o[DUMMY_POS+1:DUMMY_POS], 1'b0} + 4'h2;
  end

  assign opc_done  = rise && (state_ff == ST_OPC) && (cnt_sum == OPC_BITS);
  assign addr_done = rise && (state_ff == ST_ADDR) && (cnt_sum == ADDR_BITS);

  // where a decoded opcode goes next; nothing runs while reset recovers
  always_comb begin
    nxt_state_opc = ST_SKIP;
    if (!reset_busy_o) begin
      unique case (nxt_opc)
        OPC_LOCK, OPC_UNLOCK, OPC_READ_LOCK: nxt_state_opc = ST_ADDR;
        OPC_WRAP_READ: nxt_state_opc = quad_wide_command_mode_o ? ST_ADDR : ST_SKIP;
        default: nxt_state_opc = ST_SKIP;
      endcase
    end
  end

  // frame engine, restarted whenever chip select is high
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff   <= ST_OPC;
      opc_ff     <= 8'h00;
      addr_ff    <= 24'h00_0000;
      cnt_ff     <= 5'h00;
      dcnt_ff    <= 4'h0;
      overrun_ff <= 1'b0;
      arm_ok_ff  <= 1'b0;
    end else if (cs_n_s) begin
      state_ff   <= ST_OPC;
      cnt_ff     <= 5'h00;
      overrun_ff <= 1'b0;
    end else if (rise) begin
      unique case (state_ff)
        ST_OPC: begin
          opc_ff <= nxt_opc;
          if (cnt_sum == OPC_BITS) begin
            cnt_ff    <= 5'h00;
            state_ff  <= nxt_state_opc;
            arm_ok_ff <= armed_ff && (nxt_opc == OPC_RESET);
          end else begin
            cnt_ff <= cnt_sum;
          end
        end
        ST_ADDR: begin
          addr_ff <= nxt_addr;
          dcnt_ff <= dummy_clks;
          if (cnt_sum == ADDR_BITS) begin
            cnt_ff <= 5'h00;
            if (opc_ff == OPC_WRAP_READ) begin
              state_ff <= ST_DUMMY;
            end else if (opc_ff == OPC_READ_LOCK) begin
              state_ff <= ST_DATA;
            end else begin
              state_ff <= ST_SKIP;
            end
          end else begin
            cnt_ff <= cnt_sum;
          end
        end
        ST_DUMMY: begin
          dcnt_ff <= dcnt_ff - 4'h1;
          if (dcnt_ff == 4'h1) begin
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: state_ff <= ST_DATA;
        ST_SKIP: overrun_ff <= 1'b1; // extra clocks spoil a write-type frame
      endcase
    end
  end

  // commands act on chip select rising after an exact-length frame
  assign frame_ok   = cs_rise && (state_ff == ST_SKIP) && !overrun_ff && !reset_busy_o;
  assign ex_enter   = frame_ok && (opc_ff == OPC_ENTER_QUAD) && !quad_wide_command_mode_o
                      && quad_enable_i;
  assign ex_exit    = frame_ok && (opc_ff == OPC_EXIT_QUAD) && quad_wide_command_mode_o;
  assign ex_lock    = frame_ok && (opc_ff == OPC_LOCK) && write_enable_latch_i;
  assign ex_unlock  = frame_ok && (opc_ff == OPC_UNLOCK) && write_enable_latch_i;
  assign ex_glock   = frame_ok && (opc_ff == OPC_GLOBAL_LOCK) && write_enable_latch_i;
  assign ex_gunlock = frame_ok && (opc_ff == OPC_GLOBAL_UNLOCK) && write_enable_latch_i;
  assign ex_arm     = frame_ok && (opc_ff == OPC_RESET_ENABLE);
  assign ex_reset   = frame_ok && (opc_ff == OPC_RESET) && arm_ok_ff;

  // mode, arming, read parameters; write enable and suspend live outside
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quad_wide_command_mode_o <= 1'b0;
      armed_ff                 <= 1'b0;
      read_parameter_bits_o    <= RD_PARAM_RST;
    end else if (ex_reset) begin
      quad_wide_command_mode_o <= 1'b0;
      armed_ff                 <= 1'b0;
      read_parameter_bits_o    <= RD_PARAM_RST;
    end else begin
      if (ex_enter) begin
        quad_wide_command_mode_o <= 1'b1;
      end else if (ex_exit) begin
        quad_wide_command_mode_o <= 1'b0;
      end
      if (ex_arm) begin
        armed_ff <= 1'b1;
      end else if (opc_done) begin
        armed_ff <= 1'b0;
      end
      // loads only in quad mode; wrap field survives mode changes
      if (param_load_i && quad_wide_command_mode_o && !reset_busy_o) begin
        read_parameter_bits_o <= read_parameter_bits_i;
      end
    end
  end

  // reset recovery window and the pulse that clears outside state
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_cnt_ff  <= 12'h000;
      reset_busy_o <= 1'b0;
      sw_reset_o   <= 1'b0;
    end else begin
      sw_reset_o   <= ex_reset;
      reset_busy_o <= ex_reset || (busy_cnt_ff > 12'h001);
      if (ex_reset) begin
        busy_cnt_ff <= RESET_CYCLES;
      end else if (busy_cnt_ff != 12'h000) begin
        busy_cnt_ff <= busy_cnt_ff - 12'h001;
      end
    end
  end

  fmlr_lockmem #(
    .N  (LOCK_BITS),
    .IW (LOCK_IW)
  ) u_lock (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .set_i      (ex_lock),
    .clr_i      (ex_unlock),
    .idx_i      (fmlr_lock_index(addr_ff)),
    .all_set_i  (ex_glock || ex_reset),
    .all_clr_i  (ex_gunlock),
    .rd_a_idx_i (fmlr_lock_index(addr_ff)),
    .rd_a_o     (lock_rd),
    .rd_b_idx_i (fmlr_lock_index(prot_addr_i)),
    .rd_b_o     (lock_prot)
  );

  // wrap window: 8 << wrap field bytes, address stays inside it
  always_comb begin
    wrap_mask = 24'((7'h08 << read_parameter_bits_o[WRAP_POS+1:WRAP_POS]) - 7'h01);
    wrap_next = (rd_addr_o & ~wrap_mask) | ((rd_addr_o + 24'h00_0001) & wrap_mask);
    if (ocnt_ff != 3'h0) begin
      tx_byte = tx_ff;
    end else if (opc_ff == OPC_READ_LOCK) begin
      tx_byte = {7'h00, lock_rd};
    end else begin
      tx_byte = rd_data_i;
    end
  end

  // output shifter, updated on falling sclk, msb first
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_o      <= 4'h0;
      io_oe_n_o <= 4'hF;
      tx_ff     <= 8'h00;
      ocnt_ff   <= 3'h0;
      rd_addr_o <= 24'h00_0000;
    end else begin
      if (addr_done) begin
        rd_addr_o <= nxt_addr;
      end
      if (cs_n_s) begin
        io_oe_n_o <= 4'hF;
        ocnt_ff   <= 3'h0;
      end else if (fall && (state_ff == ST_DATA)) begin
        if (quad_wide_command_mode_o) begin
          io_o      <= tx_byte[7:4];
          io_oe_n_o <= 4'h0;
          tx_ff     <= {tx_byte[3:0], 4'h0};
          ocnt_ff   <= ocnt_ff + 3'h4;
        end else begin
          io_o      <= {2'b00, tx_byte[7], 1'b0};
          io_oe_n_o <= 4'hD;
          tx_ff     <= {tx_byte[6:0], 1'b0};
          ocnt_ff   <= ocnt_ff + 3'h1;
        end
        // fetch of the next byte starts as soon as this one is taken
        if ((ocnt_ff == 3'h0) && (opc_ff == OPC_WRAP_READ)) begin
          rd_addr_o <= wrap_next;
        end
      end
    end
  end

  // range protection: span doubles per step of the range bits
  always_comb begin
    span = (small_region_select_i ? SECTOR_SPAN : BLOCK_SPAN) << (protect_range_bits_i - 3'h1);
    if (protect_range_bits_i == 3'h0) begin
      in_range = 1'b0;
    end else if ((protect_range_bits_i == 3'h7) && !small_region_select_i) begin
      in_range = 1'b1;
    end else if (top_bottom_select_i) begin
      in_range = {1'b0, prot_addr_i} < span;
    end else begin
      in_range = {1'b0, prot_addr_i} >= (ARRAY_END - span);
    end
  end

  // protection query result for the erase/program path
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      array_protect_o <= 1'b1;
    end else if (per_region_protect_select_i) begin
      array_protect_o <= lock_prot;
    end else begin
      array_protect_o <= in_range ^ protect_complement_i;
    end
  end

endmodule
`default_nettype wire

//--- verif/fmlr_host.sv
/*
  host flash controller model: frames cs_n, sclk and io for one command.
  assumes the bench resolves each io pin from the device's enables; the host always drives.
*/
`timescale 1ns/1ps
`default_nettype none
module fmlr_host (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] io_w_i,
  output var  logic       cs_n_o,
  output var  logic       sclk_o,
  output var  logic [3:0] io_o
);
  localparam int HALF = 6; // core cycles per sclk half, margin over the 3 minimum
  // idle: deselected, clock parked low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o   = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // one frame: opcode, optional address, dummies, then nrd bytes read back
  task automatic xfer(input bit q, input logic [7:0] op, input bit ha,
                      input logic [23:0] a, input int dum, input int nrd,
                      output logic [31:0] rd);
    logic [31:0] sh;
    int          w;
    int          nin;
    w   = q ? 4 : 1;
    sh  = {op, a};
    nin = (ha ? 32 : 8) / w + dum;
    rd  = '0;
    wt(1);
    cs_n_o = 1'b0;
    for (int i = 0; i < nin + nrd * 8 / w; i++) begin
      sclk_o = 1'b0;
      // released lines toggle, so a stale level never reads back as data
      io_o = (i < nin) ? (q ? sh[31:28] : {3'h0, sh[31]}) : ~io_o;
      sh = q ? sh << 4 : sh << 1;
      wt(HALF);
      if (i >= nin) rd = q ? {rd[27:0], io_w_i} : {rd[30:0], io_w_i[1]};
      sclk_o = 1'b1;
      wt(HALF);
    end
    sclk_o = 1'b0;
    wt(HALF);
    cs_n_o = 1'b1;
    wt(HALF + 4);
  endtask
endmodule
`default_nettype wire

//--- verif/fmlr_core_props.sv
/*
  assertions on the mode, parameter, reset and protection outputs.
  assumes it is bound to fmlr_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module fmlr_core_props
  import fmlr_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cs_n_i,
  input wire logic       quad_enable_i,
  input wire logic       param_load_i,
  input wire logic [7:0] read_parameter_bits_i,
  input wire logic       per_region_protect_select_i,
  input wire logic       protect_complement_i,
  input wire logic [2:0] protect_range_bits_i,
  input wire logic [3:0] io_oe_n_o,
  input wire logic       quad_wide_command_mode_o,
  input wire logic [7:0] read_parameter_bits_o,
  input wire logic       reset_busy_o,
  input wire logic       sw_reset_o,
  input wire logic       array_protect_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [12:0] busy_len_ff;
  // length of the recovery stretch, judged the cycle it ends
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_len_ff <= 13'h0000;
    end else begin
      busy_len_ff <= reset_busy_o ? busy_len_ff + 13'h0001 : 13'h0000;
    end
  end
  AST_RST_PULSE: assert property (sw_reset_o |=> !sw_reset_o)
    else $error("reset pulse longer than one cycle");
  AST_BUSY_WITH_PULSE: assert property ($rose(sw_reset_o) |-> $rose(reset_busy_o))
    else $error("recovery did not start with the reset pulse");
  AST_BUSY_LEN: assert property ($fell(reset_busy_o) |->
      busy_len_ff >= {1'b0, RESET_CYCLES} - 13'h0002 && busy_len_ff <= {1'b0, RESET_CYCLES} + 13'h0002)
    else $error("recovery length wrong");
  AST_RESET_STATE: assert property (sw_reset_o |-> !quad_wide_command_mode_o &&
      read_parameter_bits_o == RD_PARAM_RST)
    else $error("mode or parameters not back to defaults");
  AST_RESET_LOCKS: assert property (sw_reset_o && per_region_protect_select_i |=> array_protect_o)
    else $error("locks not all set after reset");
  AST_QUAD_NEEDS_QE: assert property ($rose(quad_wide_command_mode_o) |-> $past(quad_enable_i))
    else $error("quad mode entered without quad enable");
  AST_MODE_AT_CS_HIGH: assert property ($changed(quad_wide_command_mode_o) |->
      cs_n_i && $past(cs_n_i, 2))
    else $error("mode changed inside a frame");
  AST_PARAM_SPI: assert property (param_load_i && !quad_wide_command_mode_o |=>
      $stable(read_parameter_bits_o))
    else $error("parameters loaded in spi mode");
  AST_PARAM_QUAD: assert property (param_load_i && quad_wide_command_mode_o && !reset_busy_o |=>
      read_parameter_bits_o == $past(read_parameter_bits_i))
    else $error("parameters not loaded in quad mode");
  AST_OE_IDLE: assert property (cs_n_i [*5] |-> io_oe_n_o == 4'hF)
    else $error("data pins driven while deselected");
  AST_RANGE_OFF: assert property (!per_region_protect_select_i && protect_range_bits_i == 3'h0 |=>
      array_protect_o == $past(protect_complement_i))
    else $error("empty range protection wrong");
endmodule
bind fmlr_core fmlr_core_props chk (.*);
`default_nettype wire

//--- verif/test_fmlr_core.sv
/*
  self-checking bench for the flash mode, lock and reset commands.
  assumes the host model frames commands and the array is a fixed pattern.
*/
`timescale 1ns/1ps
`default_nettype none
module test_fmlr_core
  import fmlr_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, qe, write_enable_latch, per_region_protect_select, cmp, sec, tbs, pld, qm;
  logic        cs_n, sclk, quad, busy, swr, prot;
  logic [2:0]  bp;
  logic [3:0]  hio, dio, doe_n, io_w;
  logic [7:0]  pbits, rparm, adat;
  logic [23:0] paddr, raddr;
  logic [31:0] rd;
  int          failures = 0, n_checks = 0, n_swr = 0;
  always #4 clk = ~clk;
  // pins resolve to the device wherever its enable is low
  assign io_w = (~doe_n & dio) | (doe_n & hio);
  assign adat = raddr[7:0] ^ 8'hA5;
  always @(posedge clk) if (swr === 1'b1) n_swr++;
  fmlr_host host (.core_clk_i(clk), .io_w_i(io_w), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(hio));
  fmlr_core uut (.core_clk_i(clk), .sys_rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_w),
    .io_o(dio), .io_oe_n_o(doe_n), .quad_enable_i(qe), .write_enable_latch_i(write_enable_latch),
    .per_region_protect_select_i(per_region_protect_select), .protect_complement_i(cmp), .small_region_select_i(sec),
    .top_bottom_select_i(tbs), .protect_range_bits_i(bp), .prot_addr_i(paddr),
    .param_load_i(pld), .read_parameter_bits_i(pbits), .rd_data_i(adat), .rd_addr_o(raddr),
    .quad_wide_command_mode_o(quad), .read_parameter_bits_o(rparm), .reset_busy_o(busy),
    .sw_reset_o(swr), .array_protect_o(prot));
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic got, input logic exp);
    chk(nm, {31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic cmd(input logic [7:0] op);
    host.xfer(qm, op, 1'b0, 24'h00_0000, 0, 0, rd);
  endtask
  task automatic lkop(input logic [7:0] op, input logic [23:0] a);
    host.xfer(qm, op, 1'b1, a, 0, 0, rd);
  endtask
  // the whole returned byte counts, not only its low bit
  task automatic rdlock(input logic [23:0] a, input logic e);
    host.xfer(qm, OPC_READ_LOCK, 1'b1, a, 0, 1, rd);
    chk("lock byte", rd, {31'h0000_0000, e});
  endtask
  task automatic pulse(input logic [7:0] p);
    pbits = p;
    pld = 1'b1;
    @(negedge clk);
    pld = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, well past the expected run of about 11000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] lo;
    {qe, write_enable_latch, per_region_protect_select, cmp, sec, tbs, pld, qm} = 8'h00;
    bp = 3'h0;
    paddr = 24'h12_3456;
    pbits = 8'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // mode entry only with quad enable
    chk1("mode", quad, 1'b0);
    chk("params", rparm, 32'h0000_0000);
    cmd(OPC_ENTER_QUAD);
    chk1("mode", quad, 1'b0);
    qe = 1'b1;
    cmd(OPC_ENTER_QUAD);
    qm = 1'b1;
    chk1("mode", quad, 1'b1);
    $display("test mode entry done");
    // wrapped reads over every wrap and dummy code, defaults first
    for (int c = 0; c < 4; c++) begin
      lo = 8'(8 << c) - 8'h02;
      if (c > 0) pulse({2'h0, 2'(c), 2'h0, 2'(c)});
      host.xfer(1'b1, OPC_WRAP_READ, 1'b1, {16'h0003, lo}, 2 + 2 * c, 4, rd);
      chk("wrap read", rd, {pat(lo), pat(lo + 8'h01), pat(8'h00), pat(8'h01)});
    end
    rdlock(24'h00_0000, 1'b1);
    cmd(OPC_EXIT_QUAD);
    qm = 1'b0;
    chk1("mode", quad, 1'b0);
    chk("params", rparm, 32'h0000_0033);
    pulse(8'h00);
    chk("params", rparm, 32'h0000_0033);
    $display("test wrap read done");
    // lock bits need write enable
    per_region_protect_select = 1'b1;
    rdlock(24'h12_3456, 1'b1);
    chk1("protect", prot, 1'b1);
    lkop(OPC_UNLOCK, 24'h12_0000);
    rdlock(24'h12_3456, 1'b1);
    write_enable_latch = 1'b1;
    lkop(OPC_UNLOCK, 24'h12_0000);
    rdlock(24'h12_3456, 1'b0);
    chk1("protect", prot, 1'b0);
    per_region_protect_select = 1'b0;
    cmp = 1'b1;
    repeat (2) @(negedge clk);
    chk1("protect", prot, 1'b1);
    // a 2 MB range from the bottom covers the query address, from the top it does not
    cmp = 1'b0;
    tbs = 1'b1;
    bp = 3'h6;
    repeat (2) @(negedge clk);
    chk1("protect", prot, 1'b1);
    tbs = 1'b0;
    repeat (2) @(negedge clk);
    chk1("protect", prot, 1'b0);
    bp = 3'h0;
    per_region_protect_select = 1'b1;
    lkop(OPC_LOCK, 24'h12_FFFF);
    rdlock(24'h12_3456, 1'b1);
    cmd(OPC_GLOBAL_UNLOCK);
    rdlock(24'hFF_F000, 1'b0);
    cmd(OPC_GLOBAL_LOCK);
    rdlock(24'h40_0000, 1'b1);
    $display("test locks done");
    // armed reset dropped by another command, then a real one in quad mode
    cmd(OPC_GLOBAL_UNLOCK);
    cmd(OPC_RESET_ENABLE);
    rdlock(24'h00_0000, 1'b0);
    cmd(OPC_RESET);
    chk("resets", n_swr, 0);
    cmd(OPC_ENTER_QUAD);
    qm = 1'b1;
    chk("params", rparm, 32'h0000_0033);
    // nothing pending inside before the reset pair goes out
    chk1("busy", busy, 1'b0);
    cmd(OPC_RESET_ENABLE);
    cmd(OPC_RESET);
    qm = 1'b0;
    chk("resets", n_swr, 1);
    chk1("busy", busy, 1'b1);
    chk1("mode", quad, 1'b0);
    chk("params", rparm, 32'h0000_0000);
    cmd(OPC_GLOBAL_UNLOCK);
    for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk);
    chk1("busy", busy, 1'b0);
    rdlock(24'h00_0000, 1'b1);
    $display("test software reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
